// >>> design/bms_cfg.svh
// Constants for the boot-mode select sequencer
`ifndef BMS_CFG_SVH
`define BMS_CFG_SVH

`define BMS_SEL_NAND      3'h0
`define BMS_SEL_AMEM      3'h1
`define BMS_SEL_SD        3'h2
`define BMS_SEL_UART      3'h3
`define BMS_SEL_USB       3'h4
`define BMS_SEL_SPI       3'h5
`define BMS_SEL_ETH       3'h6
`define BMS_SEL_HOST      3'h7

`define BMS_STAT_PASS_BIT 8
`define BMS_STAT_FAIL_BIT 9

`define BMS_RETRY_MAX     5'h18
`define BMS_NAND_PAGE_MAX 13'h1000
`define BMS_ECC_MAX       4'h4
`define BMS_IMG_MAX       16'h7800

`define BMS_STRAP_SETTLE  2'h3

`define BMS_CLK_HZ        20000000
`define BMS_UART_BAUD     115200
`define BMS_BAUD_DIV      (`BMS_CLK_HZ / `BMS_UART_BAUD)
`define BMS_TIMEOUT_MS    500
`define BMS_TIMEOUT_CYC   ((`BMS_CLK_HZ / 1000) * `BMS_TIMEOUT_MS)

`endif

// >>> design/bms_pkg.sv
// Types for the boot-mode select sequencer
package bms_pkg;

    typedef enum logic [2:0] {
        BMS_SRC_NAND,
        BMS_SRC_AMEM,
        BMS_SRC_SD,
        BMS_SRC_UART,
        BMS_SRC_USB,
        BMS_SRC_SPI,
        BMS_SRC_ETH,
        BMS_SRC_HOST
    } bms_src_t;

    typedef enum logic [2:0] {
        BMS_ST_STRAP,
        BMS_ST_AMEM,
        BMS_ST_START,
        BMS_ST_WAIT,
        BMS_ST_FAIL,
        BMS_ST_JUMP
    } bms_state_t;

    // Outcome of one load attempt from the media engine
    typedef struct packed {
        logic done;
        logic fail;
        logic magic_ok;
        logic desc_err;
    } bms_res_t;

    // Properties of the attached NAND part
    typedef struct packed {
        logic        width16;
        logic [12:0] page_size;
        logic [3:0]  ecc_need;
        logic        cs_hold_req;
    } bms_nand_t;

endpackage : bms_pkg

// >>> design/bms_seq.sv
// Boot-mode select and first-stage load sequencer
`include "bms_cfg.svh"

module bms_seq
    import bms_pkg::*;
#(
    parameter int TIMEOUT_CYC = `BMS_TIMEOUT_CYC
) (
    input  wire logic      clk_sys,           // 20 MHz system clock
    input  wire logic      rst_n,             // Async reset, active low
    input  wire logic [2:0] boot_select_pins, // Boot strap pins
    input  wire bms_res_t  eng_res,           // Attempt outcome
    input  wire bms_nand_t nand_info,         // NAND part properties
    input  wire logic [15:0] image_size,      // Loader image bytes
    input  wire logic      eeprom_magic,      // EEPROM magic found
    input  wire logic      host_copy_done,    // Host copy complete
    input  wire logic      uart_activity,     // Host byte received
    input  wire logic      amem_configured,   // Boot page set interface
    output bms_src_t       boot_src,          // Current source
    output logic           amem_hw_boot,      // Hardware async boot
    output logic           rom_loader_run,    // ROM loader active
    output logic           attempt_start,     // Start load pulse
    output logic           eth_boot_request,  // Send request pulse
    output logic           jump_to_loader,    // Run loader in RAM
    output logic [1:0]     boot_status,       // {fail, pass}
    output logic [4:0]     retry_count,       // Inner retries used
    output logic           nand_cs_hold,      // Keep CS low in tR
    output logic           ecc4_enable,       // 4-bit ECC active
    output logic           sd_native_hc,      // Native SD, SDHC on
    output logic           use_default_mac,   // No EEPROM magic
    output logic           uart_bit_tick,     // Bit-rate enable
    output logic           amem_page_walk     // Interface walks pages
);

    ////////////////////////////////////////////////////////////////
    // Decoding

    function automatic bms_src_t decode_sel(input logic [2:0] s);
        bms_src_t r;
        r = BMS_SRC_NAND;
        unique case (s)
            `BMS_SEL_NAND:  r = BMS_SRC_NAND;
            `BMS_SEL_AMEM:  r = BMS_SRC_AMEM;
            `BMS_SEL_SD:    r = BMS_SRC_SD;
            `BMS_SEL_UART:  r = BMS_SRC_UART;
            `BMS_SEL_USB:   r = BMS_SRC_USB;
            `BMS_SEL_SPI:   r = BMS_SRC_SPI;
            `BMS_SEL_ETH:   r = BMS_SRC_ETH;
            `BMS_SEL_HOST:  r = BMS_SRC_HOST;
        endcase
        return r;
    endfunction : decode_sel

    // NAND parts the loader cannot read end the attempt at once
    function automatic logic nand_bad(input bms_nand_t n);
        return n.width16
            || (n.page_size > `BMS_NAND_PAGE_MAX)
            || (n.ecc_need > `BMS_ECC_MAX);
    endfunction : nand_bad

    ////////////////////////////////////////////////////////////////
    // Strap synchroniser and capture

    logic [2:0] sel_meta;
    logic [2:0] sel_sync;
    logic [1:0] settle;
    logic       sel_taken;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sel_meta <= 3'h0;
            sel_sync <= 3'h0;
        end else begin
            sel_meta <= boot_select_pins;
            sel_sync <= sel_meta;
        end
    end

    // Wait for the synchroniser to fill before trusting it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            settle <= 2'h0;
        end else if (settle != `BMS_STRAP_SETTLE) begin
            settle <= settle + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Sequencer

    bms_state_t state;
    bms_state_t next_state;
    logic [31:0] tmo_cnt;
    logic        tmo_hit;
    logic        inner_retry;
    logic        img_ok;

    assign tmo_hit = (tmo_cnt >= 32'(TIMEOUT_CYC - 1));
    assign img_ok  = (image_size <= `BMS_IMG_MAX);

    // Retry inside one attempt: bad magic or bad descriptor
    always_comb begin
        inner_retry = 1'b0;
        if (retry_count < `BMS_RETRY_MAX) begin
            if (boot_src == BMS_SRC_NAND && !eng_res.magic_ok) begin
                inner_retry = 1'b1;
            end
            if (boot_src == BMS_SRC_SD && eng_res.desc_err) begin
                inner_retry = 1'b1;
            end
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            BMS_ST_STRAP: begin
                if (settle == `BMS_STRAP_SETTLE) begin
                    if (decode_sel(sel_sync) == BMS_SRC_AMEM) begin
                        next_state = BMS_ST_AMEM;
                    end else begin
                        next_state = BMS_ST_START;
                    end
                end
            end
            BMS_ST_AMEM: begin
                next_state = BMS_ST_AMEM;
            end
            BMS_ST_START: begin
                next_state = BMS_ST_WAIT;
            end
            BMS_ST_WAIT: begin
                if (boot_src == BMS_SRC_NAND && nand_bad(nand_info)) begin
                    next_state = BMS_ST_FAIL;
                end else if (boot_src == BMS_SRC_HOST) begin
                    if (host_copy_done) begin
                        next_state = BMS_ST_JUMP;
                    end
                end else if (boot_src == BMS_SRC_UART && tmo_hit) begin
                    next_state = BMS_ST_FAIL;
                end else if (eng_res.done) begin
                    // Ethernet done means every boot packet is in
                    if (eng_res.fail && inner_retry) begin
                        next_state = BMS_ST_START;
                    end else if (eng_res.fail || !img_ok) begin
                        next_state = BMS_ST_FAIL;
                    end else begin
                        next_state = BMS_ST_JUMP;
                    end
                end
            end
            BMS_ST_FAIL: begin
                next_state = BMS_ST_START;
            end
            BMS_ST_JUMP: begin
                next_state = BMS_ST_JUMP;
            end
            default: begin
                next_state = BMS_ST_STRAP;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= BMS_ST_STRAP;
        end else begin
            state <= next_state;
        end
    end

    // Source is taken once and changes only on NAND fallback
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            boot_src  <= BMS_SRC_NAND;
            sel_taken <= 1'b0;
        end else if (state == BMS_ST_STRAP && !sel_taken
                     && settle == `BMS_STRAP_SETTLE) begin
            boot_src  <= decode_sel(sel_sync);
            sel_taken <= 1'b1;
        end else if (state == BMS_ST_FAIL && boot_src == BMS_SRC_NAND) begin
            boot_src <= BMS_SRC_SD;
        end
    end

    // Inner retries restart on a fresh attempt of a source
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            retry_count <= 5'h00;
        end else if (state == BMS_ST_FAIL) begin
            retry_count <= 5'h00;
        end else if (state == BMS_ST_WAIT && next_state == BMS_ST_START) begin
            retry_count <= retry_count + 5'h01;
        end
    end

    // UART host silence counter, cleared by any received byte
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tmo_cnt <= 32'h0;
        end else if (state != BMS_ST_WAIT || uart_activity) begin
            tmo_cnt <= 32'h0;
        end else if (boot_src == BMS_SRC_UART && !tmo_hit) begin
            tmo_cnt <= tmo_cnt + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Attempt strobes

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            attempt_start    <= 1'b0;
            eth_boot_request <= 1'b0;
        end else begin
            attempt_start    <= (next_state == BMS_ST_START);
            eth_boot_request <= (next_state == BMS_ST_START)
                                && (boot_src == BMS_SRC_ETH);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Mode levels

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            amem_hw_boot    <= 1'b0;
            rom_loader_run  <= 1'b0;
            amem_page_walk  <= 1'b0;
        end else begin
            amem_hw_boot   <= (next_state == BMS_ST_AMEM);
            rom_loader_run <= (next_state == BMS_ST_START)
                              || (next_state == BMS_ST_WAIT)
                              || (next_state == BMS_ST_FAIL);
            if (state == BMS_ST_AMEM && amem_configured) begin
                amem_page_walk <= 1'b1;
            end
        end
    end

    // Jump is final; status shows last outcome
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            jump_to_loader <= 1'b0;
            boot_status    <= 2'h0;
        end else begin
            if (next_state == BMS_ST_JUMP) begin
                jump_to_loader <= 1'b1;
                boot_status    <= 2'h1;
            end else if (next_state == BMS_ST_FAIL) begin
                boot_status    <= 2'h2;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Media settings

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            nand_cs_hold <= 1'b0;
            ecc4_enable  <= 1'b0;
            sd_native_hc <= 1'b0;
        end else begin
            nand_cs_hold <= rom_loader_run && (boot_src == BMS_SRC_NAND)
                            && nand_info.cs_hold_req;
            ecc4_enable  <= rom_loader_run
                            && (boot_src == BMS_SRC_NAND);
            sd_native_hc <= rom_loader_run
                            && (boot_src == BMS_SRC_SD);
        end
    end

    // EEPROM magic is checked as each Ethernet attempt starts
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            use_default_mac <= 1'b0;
        end else if (state == BMS_ST_START && boot_src == BMS_SRC_ETH) begin
            use_default_mac <= !eeprom_magic;
        end
    end

    ////////////////////////////////////////////////////////////////
    // UART bit rate

    // Rate is derived from this block's clock; error is under 0.4 %
    bms_tick_div #(
        .DIV(`BMS_BAUD_DIV)
    ) u_baud (
        .clk_sys(clk_sys),
        .rst_n  (rst_n),
        .run    (rom_loader_run && boot_src == BMS_SRC_UART),
        .tick   (uart_bit_tick)
    );

endmodule : bms_seq

// >>> design/bms_tick_div.sv
// One-cycle enable divider for slow serial rates
module bms_tick_div #(
    parameter int DIV = 2
) (
    input  wire logic clk_sys, // System clock
    input  wire logic rst_n,   // Async reset, active low
    input  wire logic run,     // Count while high
    output logic      tick     // One-cycle pulse every DIV cycles
);
    localparam int CW = $clog2(DIV);

    logic [CW-1:0] cnt;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else if (!run) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else if (cnt == CW'(DIV - 1)) begin
            cnt  <= '0;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 1'b1;
            tick <= 1'b0;
        end
    end

endmodule : bms_tick_div

// >>> verification/bms_media_model.sv
// Behavioural boot media engine answering each load attempt
module bms_media_model
    import bms_pkg::*;
(
    input wire logic clk_sys,       // System clock
    input wire logic rst_n,         // Reset, active low
    input wire logic attempt_start, // Attempt begins
    input wire logic fail_all,      // Answer every attempt with a failure
    input wire logic mute,          // Never answer, as a dead medium
    output bms_res_t eng_res        // Outcome pulse
);
    logic [3:0] wait_cnt;
    logic       busy;
    // Latency of three cycles keeps the answer clear of the start edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            wait_cnt <= 4'h0;
            eng_res <= '0;
        end else begin
            eng_res <= '0;
            if (attempt_start && !mute) begin
                busy <= 1'b1;
                wait_cnt <= 4'h2;
            end else if (busy && wait_cnt == 4'h0) begin
                busy <= 1'b0;
                eng_res.done <= 1'b1;
                eng_res.fail <= fail_all;
                eng_res.magic_ok <= !fail_all;
                eng_res.desc_err <= fail_all;
            end else if (busy) begin
                wait_cnt <= wait_cnt - 4'h1;
            end
        end
    end
endmodule : bms_media_model

// >>> verification/bms_seq_properties.sv
// Port checker for the boot-mode select sequencer
module bms_seq_properties
    import bms_pkg::*;
#(
    parameter int TIMEOUT_CYC = 50
) (
    input wire logic        clk_sys,          // System clock
    input wire logic        rst_n,            // Reset, active low
    input wire bms_res_t    eng_res,          // Attempt outcome
    input wire bms_nand_t   nand_info,        // NAND part
    input wire logic [15:0] image_size,       // Image bytes
    input wire logic        host_copy_done,   // Host copy done
    input wire logic        amem_configured,  // Interface set up
    input wire bms_src_t    boot_src,         // Source
    input wire logic        amem_hw_boot,     // Hardware boot
    input wire logic        rom_loader_run,   // Loader active
    input wire logic        attempt_start,    // Attempt pulse
    input wire logic        eth_boot_request, // Request pulse
    input wire logic        jump_to_loader,   // Jump
    input wire logic [1:0]  boot_status,      // Fail, pass
    input wire logic [4:0]  retry_count,      // Retries used
    input wire logic        sd_native_hc,     // Native SD
    input wire logic        uart_bit_tick,    // Bit tick
    input wire logic        amem_page_walk    // Page walk
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    AST_AMEM_ONLY: assert property (
        amem_hw_boot |-> !rom_loader_run && !attempt_start) else $error("loader ran");
    // Only the NAND to SD fallback may move the source once latched
    AST_SRC_HELD: assert property (
        $past(rom_loader_run || amem_hw_boot) && $changed(boot_src)
        |-> $past(boot_src) == BMS_SRC_NAND && boot_src == BMS_SRC_SD)
        else $error("source moved");
    AST_PASS_JUMP: assert property (
        rom_loader_run && eng_res.done && !eng_res.fail && boot_src != BMS_SRC_HOST
        && image_size <= 16'h7800 |=> jump_to_loader && boot_status == 2'h1)
        else $error("no jump on pass");
    AST_ETH_REQ: assert property (
        eth_boot_request |-> attempt_start && boot_src == BMS_SRC_ETH) else $error("stray request");
    AST_SD_NATIVE: assert property (
        rom_loader_run && boot_src == BMS_SRC_SD |=> sd_native_hc) else $error("sd mode off");
    AST_RETRY_CAP: assert property (
        retry_count <= 5'h18) else $error("too many retries");
    AST_BAD_NAND: assert property (
        $rose(rom_loader_run) && boot_src == BMS_SRC_NAND && (nand_info.width16
        || nand_info.page_size > 13'h1000 || nand_info.ecc_need > 4'h4)
        |-> ##[1:3] boot_src == BMS_SRC_SD && boot_status == 2'h2) else $error("bad part");
    AST_TICK_GAP: assert property (
        uart_bit_tick |=> !uart_bit_tick [*8]) else $error("tick too close");
    AST_WALK: assert property (
        amem_hw_boot && amem_configured |-> ##[1:2] amem_page_walk) else $error("no walk");
    AST_HOST_JUMP: assert property (
        rom_loader_run && boot_src == BMS_SRC_HOST && host_copy_done |-> ##[1:2] jump_to_loader)
        else $error("host jump missing");
    ////////////////////////////////////////////////////////////////////////////
    cover property (jump_to_loader);
    cover property (boot_status == 2'h2 && boot_src == BMS_SRC_SD);
    cover property (amem_page_walk);
endmodule : bms_seq_properties

// >>> verification/bms_seq_tb_top.sv
// Self-checking testbench of the boot-mode select sequencer
module bms_seq_tb_top;
    import bms_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst_n, eeprom_magic, host_copy_done, uart_activity, amem_configured;
    logic fail_all, mute, amem_hw_boot, rom_loader_run, attempt_start, eth_boot_request;
    logic jump_to_loader, nand_cs_hold, ecc4_enable, sd_native_hc, use_default_mac;
    logic uart_bit_tick, amem_page_walk;
    logic [2:0]  boot_select_pins;
    logic [15:0] image_size;
    logic [1:0]  boot_status;
    logic [4:0]  retry_count;
    bms_nand_t   nand_info;
    bms_res_t    eng_res;
    bms_src_t    boot_src;
    int          fails, compares;
    bms_seq #(.TIMEOUT_CYC(50)) u_bms_seq (.clk_sys, .rst_n, .boot_select_pins, .eng_res,
        .nand_info, .image_size, .eeprom_magic, .host_copy_done, .uart_activity,
        .amem_configured, .boot_src, .amem_hw_boot, .rom_loader_run, .attempt_start,
        .eth_boot_request, .jump_to_loader, .boot_status, .retry_count, .nand_cs_hold,
        .ecc4_enable, .sd_native_hc, .use_default_mac, .uart_bit_tick, .amem_page_walk);
    bms_media_model u_bms_media_model (.clk_sys, .rst_n, .attempt_start, .fail_all, .mute,
        .eng_res);
    always #25 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Straps are set with reset held so they are stable across the settle window
    task automatic boot(input logic [2:0] code);
        rst_n = 1'b0;
        boot_select_pins = code;
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        // Media settings follow the loader level by one more cycle
        repeat (5) @(negedge clk_sys);
    endtask : boot
    task automatic wait_for(input int which, input int lim);
        int n;
        n = 0;
        while (!((which == 0 && jump_to_loader === 1'b1) || (which == 1 && boot_status
               === 2'h2) || (which == 2 && boot_src === BMS_SRC_SD)) && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= lim) begin
            fails++;
            $display("unexpected at %0t: wait %h ran out at %h", $time, which, n);
            results();
        end
    endtask : wait_for
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_amem();
        boot(3'h1);
        chk(amem_hw_boot, 1'b1);
        chk(rom_loader_run, 1'b0);
        boot_select_pins = 3'h0;
        repeat (5) @(negedge clk_sys);
        chk(amem_page_walk, 1'b0);
        amem_configured = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk(amem_page_walk, 1'b1);
        chk(boot_src, BMS_SRC_AMEM);
        amem_configured = 1'b0;
        $display("test async memory boot done");
    endtask : t_amem
    task automatic t_sources();
        logic [2:0] codes [5];
        codes = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
        foreach (codes[i]) begin
            boot(codes[i]);
            if (codes[i] == 3'h2) chk(sd_native_hc, 1'b1);
            if (codes[i] == 3'h6) chk(use_default_mac, 1'b1);
            wait_for(0, 40);
            chk(boot_src, codes[i]);
            chk(boot_status, 2'h1);
        end
        $display("test sources done");
    endtask : t_sources
    task automatic t_nand_fallback();
        logic [4:0] peak;
        int n;
        peak = 5'h0;
        n = 0;
        nand_info = '{1'b0, 13'h1000, 4'h4, 1'b1};
        fail_all = 1'b1;
        boot(3'h0);
        chk(ecc4_enable, 1'b1);
        chk(nand_cs_hold, 1'b1);
        while (boot_src !== BMS_SRC_SD && n < 600) begin
            if (retry_count > peak) peak = retry_count;
            @(negedge clk_sys);
            n++;
        end
        chk(peak, 5'h18);
        chk(boot_status, 2'h2);
        fail_all = 1'b0;
        wait_for(0, 60);
        chk(boot_src, BMS_SRC_SD);
        $display("test nand fallback done");
    endtask : t_nand_fallback
    task automatic t_nand_bad();
        bms_nand_t parts [3];
        parts = '{'{1'b1, 13'h0800, 4'h4, 1'b0}, '{1'b0, 13'h1001, 4'h4, 1'b0},
                  '{1'b0, 13'h0800, 4'h5, 1'b0}};
        foreach (parts[i]) begin
            nand_info = parts[i];
            mute = 1'b1;
            boot(3'h0);
            wait_for(2, 10);
            mute = 1'b0;
            chk(boot_status, 2'h2);
            wait_for(0, 40);
        end
        $display("test nand bad parts done");
    endtask : t_nand_bad
    task automatic t_retry();
        fail_all = 1'b1;
        boot(3'h4);
        wait_for(1, 40);
        chk(boot_src, BMS_SRC_USB);
        fail_all = 1'b0;
        wait_for(0, 40);
        image_size = 16'h7801;
        boot(3'h5);
        wait_for(1, 40);
        chk(boot_src, BMS_SRC_SPI);
        image_size = 16'h7800;
        wait_for(0, 40);
        chk(boot_status, 2'h1);
        $display("test retry done");
    endtask : t_retry
    task automatic t_uart();
        mute = 1'b1;
        boot(3'h3);
        repeat (30) @(negedge clk_sys);
        uart_activity = 1'b1;
        @(negedge clk_sys);
        uart_activity = 1'b0;
        repeat (40) @(negedge clk_sys);
        chk(boot_status, 2'h0);
        wait_for(1, 30);
        chk(boot_src, BMS_SRC_UART);
        mute = 1'b0;
        wait_for(0, 80);
        $display("test uart done");
    endtask : t_uart
    task automatic t_host();
        boot(3'h7);
        repeat (10) @(negedge clk_sys);
        chk(jump_to_loader, 1'b0);
        host_copy_done = 1'b1;
        @(negedge clk_sys);
        host_copy_done = 1'b0;
        wait_for(0, 3);
        chk(jump_to_loader, 1'b1);
        $display("test host done");
    endtask : t_host
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        boot_select_pins = 3'h0;
        nand_info = '0;
        image_size = 16'h1000;
        {eeprom_magic, host_copy_done, uart_activity, amem_configured} = 4'h0;
        {fail_all, mute} = 2'h0;
        fails = 0;
        compares = 0;
        @(negedge clk_sys);
        t_amem();
        t_sources();
        t_nand_fallback();
        t_nand_bad();
        t_retry();
        t_uart();
        t_host();
        results();
    end
endmodule : bms_seq_tb_top

bind bms_seq bms_seq_properties #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_bms_seq_properties (.clk_sys,
    .rst_n, .eng_res, .nand_info, .image_size, .host_copy_done, .amem_configured, .boot_src,
    .amem_hw_boot, .rom_loader_run, .attempt_start, .eth_boot_request, .jump_to_loader,
    .boot_status, .retry_count, .sd_native_hc, .uart_bit_tick, .amem_page_walk);
